//--- mio_consts.svh
// register map, field positions, reset values and timing counts
// assumes a 200 MHz clock and 32-bit wishbone data
`ifndef MIO_CONSTS_SVH
`define MIO_CONSTS_SVH
`define MIO_CTRL 8'h00
`define MIO_CMD 8'h04
`define MIO_DELAY 8'h08
`define MIO_PWM_PER 8'h0C
`define MIO_FSCALE 8'h10
`define MIO_SPEED 8'h14
`define MIO_FEED 8'h18
`define MIO_OVR 8'h1C
`define MIO_JSTEP 8'h20
`define MIO_JOG 8'h24
`define MIO_MAXRATE 8'h28
`define MIO_HOMESPD 8'h2C
`define MIO_STATUS 8'h30
`define MIO_IRQ_STAT 8'h34
`define MIO_IRQ_CLR 8'h38
`define MIO_IRQ_EN 8'h3C
`define MIO_POS0 8'h40
// control fields
`define MIO_LIM_EN 0
`define MIO_LIM_PIN 4:1
`define MIO_LIM_POL 5
`define MIO_HOME_EN 6
`define MIO_HOME_PIN 10:7
`define MIO_HOME_POL 11
`define MIO_HOME_DIR 15:12
`define MIO_DIR_POL 19:16
`define MIO_RF_EN 20
`define MIO_RF_PIN 24:21
`define MIO_RF_LVL 25
// reset values
`define MIO_CTRL_RST 32'h000F_0000
`define MIO_DELAY_RST 32'h0000_03E8
`define MIO_FSCALE_RST 32'h0000_4E20
`define MIO_OVR_RST 32'h0000_0064
`define MIO_JSTEP_RST 32'h0000_2710
`define MIO_MAXRATE_RST 32'h0000_1770
// timing
`define MIO_CLK_NS 5
`define MIO_CLK_HZ 200000000
`define MIO_US_NS 1000
`define MIO_US_CYC (`MIO_US_NS / `MIO_CLK_NS)
`define MIO_PWM_HZ 3000
`define MIO_PWM_PER_RST (`MIO_CLK_HZ / `MIO_PWM_HZ)
`define MIO_OVR_MAX 100
`endif

//--- mio_machine.sv
// machine-side model: switch bank, spindle contactors, speed pin watcher
// assumes the bench moves switches through set_sw and reads pwm_hi
`default_nettype none
module mio_machine (
   input wire logic clk_i,
   input wire logic spindle_cw_i,
   input wire logic spindle_ccw_i,
   input wire logic [15:0] out_i,
   output logic [15:0] sw_o,
   output logic clash_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int pwm_hi = 0;
   initial begin
      sw_o = 16'h0000;
      clash_o = 1'b0;
   end
   // switch levels move only just after an edge
   task automatic set_sw(input int pin, input logic lvl);
      @(posedge clk_i);
      sw_o[pin] <= lvl;
   endtask
   // pin sixteen is the speed signal only, no switched load on it
   always @(posedge clk_i) begin
      pwm_hi <= pwm_hi + int'(out_i[15] === 1'b1);
   end
   // both contactors closed at once would short the motor
   always @(posedge clk_i) begin
      if (spindle_cw_i === 1'b1 && spindle_ccw_i === 1'b1) begin
         clash_o <= 1'b1;
      end
   end
endmodule
`default_nettype wire

//--- mio_pkg.sv
// types shared by the machine i/o block
// assumes nothing beyond the consts header
`default_nettype none
package mio_pkg;
   typedef enum logic [3:0] {
      CMD_NOP, CMD_SPIN_CW, CMD_SPIN_CCW, CMD_SPIN_STOP, CMD_MIST_ON, CMD_FLOOD_ON,
      CMD_COOL_OFF, CMD_RAPID, CMD_LINEAR, CMD_ARC_CW, CMD_ARC_CCW, CMD_PLANE_XY,
      CMD_PLANE_XZ, CMD_PLANE_YZ, CMD_HOME, CMD_HALT
   } mio_cmd_t;
   typedef enum logic [1:0] {ST_IDLE, ST_BREAK, ST_MAKE, ST_WAIT} mio_state_t;
   typedef enum logic [2:0] {MD_IDLE, MD_RAPID, MD_LINEAR, MD_ARC_CW, MD_ARC_CCW,
      MD_HOME} mio_mode_t;
   typedef enum logic [1:0] {PL_XY, PL_XZ, PL_YZ} mio_plane_t;
endpackage
`default_nettype wire

//--- mio_top.sv
// machine i/o: switches, spindle/coolant sequencing, spindle pwm, motion state
// assumes a classic wishbone master and synchronous switch inputs
`include "mio_consts.svh"
`default_nettype none
// Function
// R1: limit input: enable, pin 1-16, polarity
// R2: home input: enable, pin, polarity, direction, speed
// R3: clockwise: drop ccw first, then raise cw
// R4: counter-clockwise: drop cw first, then raise ccw
// R5: spindle stop drops both spindle outputs
// R6: mist or flood raises only its own output
// R7: coolant off drops mist and flood
// R8: wait configured delay after switching on
// R9: spindle pwm always on output sixteen
// R10: pwm duty equals speed over full scale
// R11: reset indicator drives configured pin and level; a pin 16 setting drives nothing, output sixteen stays pwm
// R12: feed override 1-100 percent, overspeed 133.33
// R13: jog key adds or subtracts selected step
// R14: rapid uses max rate, ignores feed word
// R15: linear uses feed rate, stays modal
// R16: arcs cw/ccw, radius or centre; plane select
// R17: direction polarity one means high forward
// R18: spindle, coolant, pwm inactive after reset
module mio_top #(
   parameter int NAXES = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic [15:0] in_i,
   input wire logic reset_ind_i,
   output logic [15:0] out_o,
   output logic spindle_cw_o,
   output logic spindle_ccw_o,
   output logic mist_o,
   output logic flood_o,
   output logic [NAXES-1:0] dir_o,
   output logic [15:0] rate_o,
   output logic irq_o
);
   // picks pin idx (0 means pin 1) and tests active level
   function automatic logic pin_hit(input logic [15:0] v, input logic [3:0] idx,
      input logic pol);
      pin_hit = v[idx] ~^ pol;
   endfunction
   logic [31:0] ctrl_reg, ctrl_next, dly_reg, dly_next, per_reg, per_next;
   logic [31:0] fs_reg, fs_next, spd_reg, spd_next, feed_reg, feed_next;
   logic [31:0] ovr_reg, ovr_next, jstep_reg, jstep_next, max_reg, max_next;
   logic [31:0] hspd_reg, hspd_next;
   logic [2:0] ist_reg, ist_next, ien_reg, ien_next;
   logic [31:0] pos_reg [NAXES], pos_next [NAXES];
   logic [NAXES-1:0] fwd_reg, fwd_next;
   logic ack_reg, ack_next;
   logic [31:0] dat_reg, dat_next;
   logic req, wr, cmd_wr;
   logic [31:0] wmask, rd;
   mio_pkg::mio_state_t st_reg, st_next;
   mio_pkg::mio_cmd_t cmd_reg, cmd_next;
   mio_pkg::mio_mode_t mode_reg, mode_next;
   mio_pkg::mio_plane_t plane_reg, plane_next;
   logic radius_reg, radius_next;
   logic cw_reg, cw_next, ccw_reg, ccw_next, mist_reg, mist_next, fl_reg, fl_next;
   logic [31:0] dcnt_reg, dcnt_next;
   logic [7:0] us_reg, us_next;
   logic busy, done_ev;
   logic lim_act, home_act, lim_q_reg, home_q_reg;
   logic [31:0] pcnt_reg, pcnt_next;
   logic pwm_reg, pwm_next;
   logic [15:0] rate_reg, rate_next;
   logic [31:0] scaled, cap;
   logic [6:0] pct;
   assign req = cyc_i & stb_i & ~ack_reg;
   assign wr = req & we_i;
   assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
   assign busy = (st_reg != mio_pkg::ST_IDLE);
   assign cmd_wr = wr & (adr_i == `MIO_CMD) & sel_i[0] & ~busy;
   // register file and jog
   always_comb begin
      ctrl_next = ctrl_reg;
      dly_next = dly_reg;
      per_next = per_reg;
      fs_next = fs_reg;
      spd_next = spd_reg;
      feed_next = feed_reg;
      ovr_next = ovr_reg;
      jstep_next = jstep_reg;
      max_next = max_reg;
      hspd_next = hspd_reg;
      ien_next = ien_reg;
      fwd_next = fwd_reg;
      pos_next = pos_reg;
      if (wr) begin
         unique case (adr_i)
            `MIO_CTRL: ctrl_next = (ctrl_reg & ~wmask) | (dat_i & wmask);
            `MIO_DELAY: dly_next = (dly_reg & ~wmask) | (dat_i & wmask);
            `MIO_PWM_PER: per_next = (per_reg & ~wmask) | (dat_i & wmask);
            `MIO_FSCALE: fs_next = (fs_reg & ~wmask) | (dat_i & wmask);
            `MIO_SPEED: spd_next = (spd_reg & ~wmask) | (dat_i & wmask);
            `MIO_FEED: feed_next = (feed_reg & ~wmask) | (dat_i & wmask);
            `MIO_OVR: ovr_next = (ovr_reg & ~wmask) | (dat_i & wmask);
            `MIO_JSTEP: jstep_next = (jstep_reg & ~wmask) | (dat_i & wmask);
            `MIO_MAXRATE: max_next = (max_reg & ~wmask) | (dat_i & wmask);
            `MIO_HOMESPD: hspd_next = (hspd_reg & ~wmask) | (dat_i & wmask);
            `MIO_IRQ_EN: ien_next = sel_i[0] ? dat_i[2:0] : ien_reg;
            `MIO_JOG: begin
               if (sel_i[0] && 32'(dat_i[1:0]) < NAXES) begin
                  fwd_next[dat_i[1:0]] = ~dat_i[2];
                  pos_next[dat_i[1:0]] = dat_i[2] ? pos_reg[dat_i[1:0]] - jstep_reg
                     : pos_reg[dat_i[1:0]] + jstep_reg; // R13
               end
            end
            default: ;
         endcase
      end
   end
   // read mux
   always_comb begin
      rd = 32'h0000_0000;
      unique case (adr_i)
         `MIO_CTRL: rd = ctrl_reg;
         `MIO_DELAY: rd = dly_reg;
         `MIO_PWM_PER: rd = per_reg;
         `MIO_FSCALE: rd = fs_reg;
         `MIO_SPEED: rd = spd_reg;
         `MIO_FEED: rd = feed_reg;
         `MIO_OVR: rd = ovr_reg;
         `MIO_JSTEP: rd = jstep_reg;
         `MIO_MAXRATE: rd = max_reg;
         `MIO_HOMESPD: rd = hspd_reg;
         `MIO_STATUS: rd = {14'h0000, fwd_reg[3:0] & 4'(fwd_reg), plane_reg, radius_reg,
            mode_reg, home_act, lim_act, busy, pwm_reg, fl_reg, mist_reg, ccw_reg, cw_reg};
         `MIO_IRQ_STAT: rd = {29'h0000_0000, ist_reg};
         `MIO_IRQ_EN: rd = {29'h0000_0000, ien_reg};
         default: begin
            if (adr_i >= `MIO_POS0 && 32'(adr_i - `MIO_POS0) < 4 * NAXES)
               rd = pos_reg[adr_i[3:2]];
         end
      endcase
      ack_next = req;
      dat_next = req && !we_i ? rd : 32'h0000_0000;
   end
   // spindle and coolant sequencer
   always_comb begin
      st_next = st_reg;
      cmd_next = cmd_reg;
      mode_next = mode_reg;
      plane_next = plane_reg;
      radius_next = radius_reg;
      cw_next = cw_reg;
      ccw_next = ccw_reg;
      mist_next = mist_reg;
      fl_next = fl_reg;
      dcnt_next = dcnt_reg;
      us_next = us_reg;
      done_ev = 1'b0;
      unique case (st_reg)
         mio_pkg::ST_IDLE: begin
            if (cmd_wr) begin
               cmd_next = mio_pkg::mio_cmd_t'(dat_i[3:0]);
               unique case (mio_pkg::mio_cmd_t'(dat_i[3:0]))
                  mio_pkg::CMD_SPIN_CW, mio_pkg::CMD_SPIN_CCW: st_next = mio_pkg::ST_BREAK;
                  mio_pkg::CMD_MIST_ON, mio_pkg::CMD_FLOOD_ON: st_next = mio_pkg::ST_MAKE;
                  mio_pkg::CMD_SPIN_STOP: begin
                     cw_next = 1'b0; // R5
                     ccw_next = 1'b0; // R5
                  end
                  mio_pkg::CMD_COOL_OFF: begin
                     mist_next = 1'b0; // R7
                     fl_next = 1'b0; // R7
                  end
                  mio_pkg::CMD_RAPID: mode_next = mio_pkg::MD_RAPID; // R14
                  mio_pkg::CMD_LINEAR: mode_next = mio_pkg::MD_LINEAR; // R15
                  mio_pkg::CMD_ARC_CW, mio_pkg::CMD_ARC_CCW: begin
                     mode_next = dat_i[3:0] == 4'(mio_pkg::CMD_ARC_CW) ? mio_pkg::MD_ARC_CW
                        : mio_pkg::MD_ARC_CCW; // R16
                     radius_next = dat_i[4]; // R16
                  end
                  mio_pkg::CMD_PLANE_XY: plane_next = mio_pkg::PL_XY; // R16
                  mio_pkg::CMD_PLANE_XZ: plane_next = mio_pkg::PL_XZ;
                  mio_pkg::CMD_PLANE_YZ: plane_next = mio_pkg::PL_YZ;
                  mio_pkg::CMD_HOME: mode_next = mio_pkg::MD_HOME; // R2
                  mio_pkg::CMD_HALT: mode_next = mio_pkg::MD_IDLE;
                  mio_pkg::CMD_NOP: ;
               endcase
            end
            if (mode_reg == mio_pkg::MD_HOME && home_act)
               mode_next = mio_pkg::MD_IDLE; // R2
         end
         mio_pkg::ST_BREAK: begin
            if (cmd_reg == mio_pkg::CMD_SPIN_CW) ccw_next = 1'b0; // R3
            else cw_next = 1'b0; // R4
            st_next = mio_pkg::ST_MAKE;
         end
         mio_pkg::ST_MAKE: begin
            unique case (cmd_reg)
               mio_pkg::CMD_SPIN_CW: cw_next = 1'b1; // R3
               mio_pkg::CMD_SPIN_CCW: ccw_next = 1'b1; // R4
               mio_pkg::CMD_MIST_ON: mist_next = 1'b1; // R6
               default: fl_next = 1'b1; // R6
            endcase
            dcnt_next = dly_reg;
            us_next = 8'h00;
            st_next = mio_pkg::ST_WAIT;
         end
         mio_pkg::ST_WAIT: begin
            if (dcnt_reg == 32'h0000_0000) begin
               st_next = mio_pkg::ST_IDLE; // R8
               done_ev = 1'b1;
            end else if (us_reg == 8'(`MIO_US_CYC - 1)) begin
               us_next = 8'h00;
               dcnt_next = dcnt_reg - 32'h0000_0001; // R8
            end else begin
               us_next = us_reg + 8'h01;
            end
         end
      endcase
   end

   // switches, override, pwm, interrupts
   assign lim_act = ctrl_reg[`MIO_LIM_EN]
      & pin_hit(in_i, ctrl_reg[`MIO_LIM_PIN], ctrl_reg[`MIO_LIM_POL]); // R1
   assign home_act = ctrl_reg[`MIO_HOME_EN]
      & pin_hit(in_i, ctrl_reg[`MIO_HOME_PIN], ctrl_reg[`MIO_HOME_POL]); // R2
   always_comb begin
      pct = ovr_reg[6:0] == 7'h00 ? 7'h01 : ovr_reg[6:0] > 7'(`MIO_OVR_MAX) ?
         7'(`MIO_OVR_MAX) : ovr_reg[6:0]; // R12
      scaled = 32'((feed_reg[15:0] * pct) / `MIO_OVR_MAX); // R12
      cap = ovr_reg[7] ? 32'((max_reg[15:0] * 17'd4) / 3) : {16'h0000, max_reg[15:0]}; // R12
      unique case (mode_reg)
         mio_pkg::MD_IDLE: rate_next = 16'h0000;
         mio_pkg::MD_RAPID: rate_next = max_reg[15:0]; // R14
         mio_pkg::MD_HOME: rate_next = hspd_reg[15:0]; // R2
         default: rate_next = 16'(scaled > cap ? cap : scaled); // R15
      endcase
      if (lim_act) rate_next = 16'h0000;
      pcnt_next = pcnt_reg + 32'h0000_0001 >= per_reg ? 32'h0000_0000
         : pcnt_reg + 32'h0000_0001; // R10
      pwm_next = (cw_reg | ccw_reg)
         & (48'(pcnt_reg) * 48'(fs_reg[15:0]) < 48'(spd_reg[15:0]) * 48'(per_reg)); // R10
      ist_next = (ist_reg & ~(wr && adr_i == `MIO_IRQ_CLR && sel_i[0] ? dat_i[2:0] : 3'h0))
         | {done_ev, home_act & ~home_q_reg, lim_act & ~lim_q_reg};
   end

   // outputs
   always_comb begin
      out_o = 16'h0000;
      if (ctrl_reg[`MIO_RF_EN] && reset_ind_i && ctrl_reg[`MIO_RF_PIN] != 4'hF)
         out_o[ctrl_reg[`MIO_RF_PIN]] = ctrl_reg[`MIO_RF_LVL]; // R11
      out_o[15] = pwm_reg; // R9
   end
   for (genvar g = 0; g < NAXES; g++) begin : g_dir
      assign dir_o[g] = (mode_reg == mio_pkg::MD_HOME ? ctrl_reg[12 + (g % 4)] : fwd_reg[g])
         ~^ ctrl_reg[16 + (g % 4)]; // R17
   end
   assign spindle_cw_o = cw_reg;
   assign spindle_ccw_o = ccw_reg;
   assign mist_o = mist_reg;
   assign flood_o = fl_reg;
   assign rate_o = rate_reg;
   assign dat_o = dat_reg;
   assign ack_o = ack_reg;
   assign irq_o = |(ist_reg & ien_reg);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= `MIO_CTRL_RST;
         dly_reg <= `MIO_DELAY_RST;
         per_reg <= `MIO_PWM_PER_RST;
         fs_reg <= `MIO_FSCALE_RST;
         spd_reg <= 32'h0000_0000;
         feed_reg <= 32'h0000_0000;
         ovr_reg <= `MIO_OVR_RST;
         jstep_reg <= `MIO_JSTEP_RST;
         max_reg <= `MIO_MAXRATE_RST;
         hspd_reg <= 32'h0000_0000;
         ien_reg <= 3'h0;
         ist_reg <= 3'h0;
         fwd_reg <= '1;
         for (int i = 0; i < NAXES; i++) pos_reg[i] <= 32'h0000_0000;
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
         st_reg <= mio_pkg::ST_IDLE;
         cmd_reg <= mio_pkg::CMD_NOP;
         mode_reg <= mio_pkg::MD_IDLE;
         plane_reg <= mio_pkg::PL_XY; // R16
         radius_reg <= 1'b0;
         cw_reg <= 1'b0; // R18
         ccw_reg <= 1'b0;
         mist_reg <= 1'b0;
         fl_reg <= 1'b0;
         dcnt_reg <= 32'h0000_0000;
         us_reg <= 8'h00;
         lim_q_reg <= 1'b0;
         home_q_reg <= 1'b0;
         pcnt_reg <= 32'h0000_0000;
         pwm_reg <= 1'b0; // R18
         rate_reg <= 16'h0000;
      end else begin
         ctrl_reg <= ctrl_next;
         dly_reg <= dly_next;
         per_reg <= per_next;
         fs_reg <= fs_next;
         spd_reg <= spd_next;
         feed_reg <= feed_next;
         ovr_reg <= ovr_next;
         jstep_reg <= jstep_next;
         max_reg <= max_next;
         hspd_reg <= hspd_next;
         ien_reg <= ien_next;
         ist_reg <= ist_next;
         fwd_reg <= fwd_next;
         pos_reg <= pos_next;
         ack_reg <= ack_next;
         dat_reg <= dat_next;
         st_reg <= st_next;
         cmd_reg <= cmd_next;
         mode_reg <= mode_next;
         plane_reg <= plane_next;
         radius_reg <= radius_next;
         cw_reg <= cw_next;
         ccw_reg <= ccw_next;
         mist_reg <= mist_next;
         fl_reg <= fl_next;
         dcnt_reg <= dcnt_next;
         us_reg <= us_next;
         lim_q_reg <= lim_act;
         home_q_reg <= home_act;
         pcnt_reg <= pcnt_next;
         pwm_reg <= pwm_next;
         rate_reg <= rate_next;
      end
   end

   // checks
   spin_excl_a: assert property (@(posedge clk_i) disable iff (rst_i) !(cw_reg && ccw_reg)) // R3
      else $error("both spindle outputs on");
   cw_order_a: assert property (@(posedge clk_i) disable iff (rst_i) // R3
      $rose(cw_reg) |-> $past(!ccw_reg) && !ccw_reg) else $error("cw raised before ccw drop");
   ccw_order_a: assert property (@(posedge clk_i) disable iff (rst_i) // R4
      $rose(ccw_reg) |-> $past(!cw_reg) && !cw_reg) else $error("ccw raised before cw drop");
   spin_stop_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
      cmd_wr && dat_i[3:0] == 4'(mio_pkg::CMD_SPIN_STOP) |=> !cw_reg && !ccw_reg)
      else $error("stop left spindle on");
   mist_keep_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      $rose(fl_reg) |-> $stable(mist_reg)) else $error("flood changed mist");
   cool_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
      cmd_wr && dat_i[3:0] == 4'(mio_pkg::CMD_COOL_OFF) |=> !mist_reg && !fl_reg)
      else $error("coolant off failed");
   delay_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R8
      $rose(cw_reg) && dly_reg != 0 |-> busy [*3]) else $error("delay skipped");
   pwm_pin_a: assert property (@(posedge clk_i) disable iff (rst_i) // R9
      out_o[15] == pwm_reg) else $error("pwm not on output sixteen");
   pwm_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // R18
      !cw_reg && !ccw_reg |=> !pwm_reg) else $error("pwm with spindle off");
   rst_follow_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
      ctrl_reg[`MIO_RF_EN] && reset_ind_i && ctrl_reg[`MIO_RF_PIN] != 4'hF
      |-> out_o[ctrl_reg[`MIO_RF_PIN]] == ctrl_reg[`MIO_RF_LVL]) else $error("reset pin wrong");
   rapid_rate_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
      mode_reg == mio_pkg::MD_RAPID && !lim_act |=> rate_reg == $past(max_reg[15:0]))
      else $error("rapid rate wrong");
endmodule
`default_nettype wire

//--- mio_top_tb.sv
// self-checking bench for the machine i/o block
// assumes mio_top, mio_machine and the consts header
`include "mio_consts.svh"
`default_nettype none
module mio_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic rind = 1'b0;
   logic [31:0] dat_o;
   logic ack_o, cw, ccw, mist, flood, irq, clash;
   logic [15:0] out_o, rate, sw;
   logic [3:0] dir;
   int fail_count = 0;
   int n_compared = 0;
   always #2.5 clk_i = ~clk_i;
   mio_top #(.NAXES(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
      .in_i(sw), .reset_ind_i(rind), .out_o(out_o), .spindle_cw_o(cw),
      .spindle_ccw_o(ccw), .mist_o(mist), .flood_o(flood), .dir_o(dir), .rate_o(rate),
      .irq_o(irq));
   mio_machine mach (.clk_i(clk_i), .spindle_cw_i(cw), .spindle_ccw_i(ccw), .out_i(out_o),
      .sw_o(sw), .clash_o(clash));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      rdat = dat_o;
      chk("ack", {31'h0, ack_o}, 32'h1);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input string what, input logic [31:0] exp);
      wb(1'b0, a, 32'h0000_0000);
      chk(what, rdat, exp);
   endtask
   task automatic cyc_n(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // wait for the delay-done interrupt, returning the cycles spent
   task automatic wait_irq(output int n);
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
         @(posedge clk_i);
         n++;
      end
      chk("irq seen", {31'h0, irq}, 32'h1);
      wb(1'b1, `MIO_IRQ_CLR, 32'h0000_0004);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         wb(1'b0, `MIO_STATUS, 32'h0000_0000);
         n++;
      end while (rdat[5] !== 1'b0 && n < 400);
      chk("idle", {31'h0, rdat[5]}, 32'h0);
   endtask
   task automatic t_reset();
      chk("spindle coolant", {cw, ccw, mist, flood}, 4'h0);
      chk("out", out_o, 16'h0000);
      chk("dir", dir, 4'hF);
      rd(`MIO_CTRL, "ctrl", `MIO_CTRL_RST);
      rd(`MIO_DELAY, "delay", `MIO_DELAY_RST);
      rd(`MIO_STATUS, "status", 32'h0003_C000);
      rd(8'hFC, "unmapped", 32'h0000_0000);
   endtask
   task automatic t_spindle();
      int n, f, r, p;
      f = -1;
      r = -1;
      wb(1'b1, `MIO_DELAY, 32'h0000_0002);
      wb(1'b1, `MIO_IRQ_EN, 32'h0000_0004);
      wb(1'b1, `MIO_PWM_PER, 32'h0000_000A);
      wb(1'b1, `MIO_FSCALE, 32'h0000_000A);
      wb(1'b1, `MIO_SPEED, 32'h0000_0003);
      wb(1'b1, `MIO_CMD, 32'h0000_0002);
      wait_irq(n);
      chk("delay span", {31'h0, n >= 400 && n <= 420}, 32'h1);
      chk("ccw on", {cw, ccw}, 2'b01);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      wb(1'b1, `MIO_CMD, 32'h0000_0001);
      #1;
      for (int i = 0; i < 10; i++) begin
         if (f < 0 && ccw === 1'b0) f = i;
         if (r < 0 && cw === 1'b1) r = i;
         cyc_n(1);
      end
      chk("break before make", {31'h0, f >= 0 && r > f}, 32'h1);
      wait_irq(n);
      chk("no clash", {31'h0, clash}, 32'h0);
      cyc_n(1);
      p = mach.pwm_hi;
      cyc_n(20);
      chk("pwm 3 of 10", mach.pwm_hi - p, 32'd6);
      chk("low outs", out_o[14:0], 15'h0000);
      wb(1'b1, `MIO_SPEED, 32'h0000_000A);
      cyc_n(3);
      p = mach.pwm_hi;
      cyc_n(20);
      chk("pwm full", mach.pwm_hi - p, 32'd20);
      wb(1'b1, `MIO_IRQ_EN, 32'h0000_0000);
      wb(1'b1, `MIO_CMD, 32'h0000_0004);
      wait_idle();
      chk("mist only", {mist, flood}, 2'b10);
      rd(`MIO_IRQ_STAT, "irq stat", 32'h0000_0004);
      chk("irq masked", {31'h0, irq}, 32'h0);
      wb(1'b1, `MIO_CMD, 32'h0000_0005);
      wait_idle();
      chk("mist flood", {mist, flood}, 2'b11);
      wb(1'b1, `MIO_CMD, 32'h0000_0006);
      cyc_n(2);
      chk("coolant off", {mist, flood}, 2'b00);
      wb(1'b1, `MIO_CMD, 32'h0000_0003);
      cyc_n(3);
      chk("spindle off", {cw, ccw}, 2'b00);
      p = mach.pwm_hi;
      cyc_n(20);
      chk("pwm idle", mach.pwm_hi - p, 32'd0);
   endtask
   task automatic t_motion();
      wb(1'b1, `MIO_FEED, 32'h0000_03E8);
      wb(1'b1, `MIO_OVR, 32'h0000_0032);
      wb(1'b1, `MIO_CMD, 32'h0000_0008);
      cyc_n(3);
      chk("feed 50pct", rate, 16'd500);
      wb(1'b1, `MIO_CMD, 32'h0000_000B);
      cyc_n(3);
      chk("modal", rate, 16'd500);
      wb(1'b1, `MIO_CMD, 32'h0000_0007);
      cyc_n(3);
      chk("rapid", rate, 16'd6000);
      wb(1'b1, `MIO_OVR, 32'h0000_00E4);
      wb(1'b1, `MIO_FEED, 32'h0000_2710);
      wb(1'b1, `MIO_CMD, 32'h0000_0008);
      cyc_n(3);
      chk("overspeed cap", rate, 16'd8000);
      wb(1'b1, `MIO_CTRL, 32'h000F_003F);
      mach.set_sw(15, 1'b1);
      cyc_n(3);
      chk("limit stop", rate, 16'd0);
      rd(`MIO_STATUS, "status", 32'h0003_C240);
      wb(1'b1, `MIO_CTRL, 32'h000F_001F);
      cyc_n(3);
      chk("limit low pol", rate, 16'd8000);
      wb(1'b1, `MIO_CTRL, 32'h000F_0000);
      mach.set_sw(15, 1'b0);
      for (int c = 9; c <= 10; c++) begin
         wb(1'b1, `MIO_CMD, 32'(c + 16));
         rd(`MIO_STATUS, "arc", 32'h0003_C800 | 32'((c - 6) << 8));
      end
      for (int c = 12; c >= 11; c--) begin
         wb(1'b1, `MIO_CMD, 32'(c));
         rd(`MIO_STATUS, "plane", 32'h0003_CC00 | 32'((c - 11) << 12));
      end
      wb(1'b1, `MIO_CTRL, 32'h0000_0000);
      cyc_n(2);
      chk("dir pol 0", dir, 4'h0);
      wb(1'b1, `MIO_CTRL, 32'h000F_0000);
      wb(1'b1, `MIO_JOG, 32'h0000_0001);
      rd(8'h44, "jog plus", 32'h0000_2710);
      wb(1'b1, `MIO_JOG, 32'h0000_0005);
      wb(1'b1, `MIO_JOG, 32'h0000_0005);
      rd(8'h44, "jog minus", 32'hFFFF_D8F0);
      chk("dir reverse", dir, 4'hD);
   endtask
   task automatic t_home_rf();
      wb(1'b1, `MIO_HOMESPD, 32'h0000_012C);
      wb(1'b1, `MIO_CTRL, 32'h000F_5940);
      wb(1'b1, `MIO_CMD, 32'h0000_000E);
      cyc_n(3);
      chk("home rate", rate, 16'd300);
      chk("home dir", dir, 4'h5);
      mach.set_sw(2, 1'b1);
      cyc_n(4);
      chk("home stop", rate, 16'd0);
      wb(1'b1, `MIO_CTRL, 32'h029F_0000);
      rind <= 1'b1;
      cyc_n(2);
      chk("reset follow", out_o, 16'h0010);
      @(posedge clk_i);
      rind <= 1'b0;
      cyc_n(2);
      chk("reset released", out_o, 16'h0000);
   endtask
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #100us;
      fail_count++;
      complete_run();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      cyc_n(1);
      t_reset();
      t_spindle();
      t_motion();
      t_home_rf();
      complete_run();
   end
endmodule
`default_nettype wire
